// file: tsc_pkg.sv
package tsc_pkg;

	// clock and working-state timing
	localparam int CLK_MHZ = 50;
	localparam int XTAL_SETTLE_US = 400;
	localparam int TUNE_US = 370;
	localparam int US_CYC = CLK_MHZ;
	localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_US * CLK_MHZ;
	localparam int TUNE_CYC = TUNE_US * CLK_MHZ;
	localparam int MS_CYC = 1000 * CLK_MHZ;
	localparam int CORE_RESET_MS = 1;

	// stop time, in milliseconds
	localparam logic [6:0] STOP_MS_RST = 7'h14;
	localparam logic [6:0] STOP_MS_SHORT_MIN = 7'h02;
	localparam logic [6:0] STOP_MS_SHORT_MAX = 7'h09;
	localparam logic [6:0] STOP_MS_LONG_MIN = 7'h14;
	localparam logic [6:0] STOP_MS_LONG_MAX = 7'h5a;
	localparam logic [6:0] STOP_MS_LONG_STEP = 7'h0a;

	// amplifier ramp: code 0 is immediate, code n in 1..11 is 2^(n-1) us
	localparam logic [3:0] RAMP_SEL_MAX = 4'hb;
	localparam logic [10:0] RAMP_FULL = 11'h400;
	localparam logic [7:0] PA_LEVEL_MAX = 8'hff;

	// two-wire port framing
	localparam logic [5:0] RESYNC_ZEROS = 6'h20;
	localparam logic [3:0] FRAME_BITS_M1 = 4'hf;
	localparam logic [3:0] ADDR_BITS_END = 4'h7;
	localparam logic [15:0] PORT_RESYNC_PAT = 16'h8d00;
	localparam logic [15:0] PORT_RELEASE_PAT = 16'hbd01;
	localparam logic [15:0] CORE_RESET_PAT = 16'h8d02;

	typedef enum logic [1:0] {
		TSC_SLEEP,
		TSC_OSC_WARMUP,
		TSC_TUNE,
		TSC_TRANSMIT
	} tsc_state_t;

endpackage

// file: tsc_sync.sv
module tsc_sync import tsc_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// asynchronous level in
	input wire logic async_in,
	// filtered level and one-cycle change pulse
	output logic level_r,
	output logic change
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only once the last two stages agree
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	assign change = (s2_r == s3_r) && (s3_r != level_r);

endmodule

// file: tsc_core.sv
// Functional notes
// - ramp options zero or 1..1024 us powers
// - ramp only applies under on-off keying
// - zero ramp immediate; ramp down equals up
// - four states: sleep, warmup, tune, transmit
// - sleep keeps every internal function off
// - configured data-pin edge starts oscillator warmup
// - no amplifier or data before tune completes
// - transmit modulates pin; ends after low stop time
// - core reset stops transmission within 1 ms
// - stop time 2..9 ms, 20..90 ms steps
// - rising mode: pin ignored until tuning ends
// - falling mode: pin low in warmup, ignored tuning
// - resync is 32 zeros then 0x8d00
// - after resync, pin edges never start transmission
// - access is 16 bits, sampled on falling clock
// - release 0xbd01 re-enables pin edge triggering
// - core reset clears all but port, calibrates, sleeps
// - device drives data during last eight read clocks
module tsc_core import tsc_pkg::*; #(
	parameter int XTAL_CYC = XTAL_SETTLE_CYC,
	parameter int TUNE_CYC_P = TUNE_CYC,
	parameter int MS_CYC_P = MS_CYC
) (
	// system clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// two-wire port pins; data pin also carries the modulation data
	input wire logic port_clk,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe_n,
	// configuration
	input wire logic start_falling,
	input wire logic ook_mode,
	input wire logic [3:0] ramp_sel,
	input wire logic [6:0] stop_ms,
	// status and analog controls
	output tsc_state_t state_r,
	output logic osc_en,
	output logic synth_en,
	output logic pa_en,
	output logic tx_bit_r,
	output logic [7:0] pa_level_r,
	output logic port_locked,
	output logic calib_busy
);

	// refused at elaboration: the timers are 16 bits wide and the ms count, which counts clocks, must span at least one us
	if (XTAL_CYC < 1 || TUNE_CYC_P < 1 || MS_CYC_P < US_CYC) begin : g_timing_low
		$error("tsc_core: timing counts out of range");
	end
	if (XTAL_CYC > 65535 || TUNE_CYC_P > 65535 || MS_CYC_P > 65535) begin : g_timing_high
		$error("tsc_core: timing counts exceed 16-bit counter");
	end

	// ---------------- link domain, clocked by the port clock ----------------
	logic [5:0] zero_run_r;
	logic [15:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic after_zeros_r;
	logic port_locked_r;
	logic creset_tgl_r;
	logic read_req_r;
	logic [7:0] reg_mem [0:63];
	logic [15:0] shift_nxt;
	logic drv_r;
	logic [7:0] drv_sh_r;

	logic realign;

	assign shift_nxt = {shift_r[14:0], data_in};
	// the 32nd zero realigns; longer runs keep realigning so the frame starts at the first one
	assign realign = (zero_run_r >= RESYNC_ZEROS - 6'h01) && !data_in;

	// bits are sampled on the falling port clock edge
	always_ff @(negedge port_clk or negedge reset_n) begin
		if (!reset_n) begin
			zero_run_r <= 6'h00;
		end else if (data_in) begin
			zero_run_r <= 6'h00;
		end else if (zero_run_r != RESYNC_ZEROS) begin
			zero_run_r <= zero_run_r + 6'h01;
		end
	end

	// a run of 32 zeros realigns framing; the next 16 bits are a resync candidate
	always_ff @(negedge port_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_r <= 16'h0000;
			bit_cnt_r <= 4'h0;
			after_zeros_r <= 1'b0;
		end else if (realign) begin
			shift_r <= 16'h0000;
			bit_cnt_r <= 4'h0;
			after_zeros_r <= 1'b1;
		end else begin
			shift_r <= shift_nxt;
			bit_cnt_r <= bit_cnt_r + 4'h1;
			if (bit_cnt_r == FRAME_BITS_M1) begin
				after_zeros_r <= 1'b0;
			end
		end
	end

	// command decode at the end of each 16-bit frame
	always_ff @(negedge port_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_locked_r <= 1'b0;
			creset_tgl_r <= 1'b0;
		end else if (bit_cnt_r == FRAME_BITS_M1 && !realign) begin
			if (after_zeros_r && shift_nxt == PORT_RESYNC_PAT) begin
				port_locked_r <= 1'b1;
			end else if (port_locked_r && shift_nxt == PORT_RELEASE_PAT) begin
				port_locked_r <= 1'b0;
			end else if (port_locked_r && shift_nxt == CORE_RESET_PAT) begin
				creset_tgl_r <= ~creset_tgl_r;
			end
		end
	end

	// register write: leading one, write bit zero, address, data
	always_ff @(negedge port_clk) begin
		if (bit_cnt_r == FRAME_BITS_M1 && port_locked_r && !after_zeros_r
			&& shift_nxt[15:14] == 2'b10 && shift_nxt != CORE_RESET_PAT) begin
			reg_mem[shift_nxt[13:8]] <= shift_nxt[7:0];
		end
	end

	always_ff @(negedge port_clk or negedge reset_n) begin
		if (!reset_n) begin
			read_req_r <= 1'b0;
		end else if (bit_cnt_r == ADDR_BITS_END) begin
			read_req_r <= port_locked_r && !after_zeros_r && shift_nxt[7:6] == 2'b11;
		end else if (bit_cnt_r == FRAME_BITS_M1) begin
			read_req_r <= 1'b0;
		end
	end

	// read data leaves on the rising clock; driver drops at the rising edge after the frame
	always_ff @(posedge port_clk or negedge reset_n) begin
		if (!reset_n) begin
			drv_r <= 1'b0;
			drv_sh_r <= 8'h00;
		end else if (read_req_r && !drv_r) begin
			drv_r <= 1'b1;
			drv_sh_r <= reg_mem[shift_r[5:0]];
		end else if (drv_r && read_req_r) begin
			drv_sh_r <= {drv_sh_r[6:0], 1'b0};
		end else begin
			drv_r <= 1'b0;
		end
	end

	assign data_out = drv_sh_r[7];
	assign data_oe_n = ~drv_r;

	// ---------------- system domain ----------------
	logic pin_level;
	logic pin_change;
	logic locked_level;
	logic creset_level;
	logic creset_event;

	// every pin and cross-domain signal goes through three flops
	tsc_sync u_pin_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in(data_in),
		.level_r(pin_level),
		.change(pin_change)
	);

	tsc_sync u_lock_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in(port_locked_r),
		.level_r(locked_level),
		.change()
	);

	tsc_sync u_creset_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in(creset_tgl_r),
		.level_r(creset_level),
		.change(creset_event)
	);

	assign port_locked = locked_level;

	logic start_edge;
	logic [15:0] wait_cnt_r;
	logic [15:0] ms_cnt_r;
	logic [15:0] cal_cnt_r;
	logic [6:0] low_ms_r;
	logic [6:0] stop_ms_eff;
	logic stop_legal;
	logic low_ms_tick;

	// only the configured edge counts, and only while the port is released
	// pin_level still holds the old level while pin_change pulses
	assign start_edge = pin_change && !locked_level && !calib_busy
		&& (start_falling ? pin_level : !pin_level);

	// stop-time setting: 2..9 ms in 1 ms steps or 20..90 ms in 10 ms steps
	assign stop_legal = (stop_ms >= STOP_MS_SHORT_MIN && stop_ms <= STOP_MS_SHORT_MAX)
		|| (stop_ms >= STOP_MS_LONG_MIN && stop_ms <= STOP_MS_LONG_MAX
		&& (stop_ms % STOP_MS_LONG_STEP) == 7'h00);
	assign stop_ms_eff = stop_legal ? stop_ms : STOP_MS_RST;

	// core reset returns the state to sleep at once, far inside the 1 ms budget
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= TSC_SLEEP;
		end else if (creset_event) begin
			state_r <= TSC_SLEEP;
		end else begin
			case (state_r)
				TSC_SLEEP: begin
					if (start_edge) begin
						state_r <= TSC_OSC_WARMUP;
					end
				end
				TSC_OSC_WARMUP: begin
					if (wait_cnt_r == 16'(XTAL_CYC - 1)) begin
						state_r <= TSC_TUNE;
					end
				end
				TSC_TUNE: begin
					if (wait_cnt_r == 16'(TUNE_CYC_P - 1)) begin
						state_r <= TSC_TRANSMIT;
					end
				end
				TSC_TRANSMIT: begin
					if (low_ms_tick && low_ms_r == stop_ms_eff - 7'h01) begin
						state_r <= TSC_SLEEP;
					end
				end
				default: begin
					state_r <= TSC_SLEEP;
				end
			endcase
		end
	end

	// warmup and tune timer restarts on each state change
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_cnt_r <= 16'h0000;
		end else if (creset_event || state_r == TSC_SLEEP || state_r == TSC_TRANSMIT) begin
			wait_cnt_r <= 16'h0000;
		end else if ((state_r == TSC_OSC_WARMUP && wait_cnt_r == 16'(XTAL_CYC - 1))
			|| (state_r == TSC_TUNE && wait_cnt_r == 16'(TUNE_CYC_P - 1))) begin
			wait_cnt_r <= 16'h0000;
		end else begin
			wait_cnt_r <= wait_cnt_r + 16'h0001;
		end
	end

	// low-time measurement restarts whenever the pin is high
	assign low_ms_tick = ms_cnt_r == 16'(MS_CYC_P - 1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ms_cnt_r <= 16'h0000;
			low_ms_r <= 7'h00;
		end else if (state_r != TSC_TRANSMIT || pin_level || creset_event) begin
			ms_cnt_r <= 16'h0000;
			low_ms_r <= 7'h00;
		end else if (low_ms_tick) begin
			ms_cnt_r <= 16'h0000;
			low_ms_r <= low_ms_r + 7'h01;
		end else begin
			ms_cnt_r <= ms_cnt_r + 16'h0001;
		end
	end

	// calibration after core reset; start edges are blocked meanwhile
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cal_cnt_r <= 16'h0000;
		end else if (creset_event) begin
			cal_cnt_r <= 16'(MS_CYC_P * CORE_RESET_MS);
		end else if (cal_cnt_r != 16'h0000) begin
			cal_cnt_r <= cal_cnt_r - 16'h0001;
		end
	end

	assign calib_busy = cal_cnt_r != 16'h0000;

	// sleep keeps every function off
	assign osc_en = state_r != TSC_SLEEP;
	assign synth_en = state_r == TSC_TUNE || state_r == TSC_TRANSMIT;
	assign pa_en = state_r == TSC_TRANSMIT;

	// pin level is don't-care until tuning ends, so data is gated by state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_bit_r <= 1'b0;
		end else begin
			// a core reset leaves transmit at this edge, so no data bit may follow it
			tx_bit_r <= (state_r == TSC_TRANSMIT) && !creset_event && pin_level;
		end
	end

	// amplifier ramp: position 0..1024 moves by 1024/ramp_us each microsecond
	logic [5:0] us_cnt_r;
	logic us_tick;
	logic [10:0] ramp_pos_r;
	logic [10:0] ramp_step;
	logic ramp_target;
	logic [3:0] ramp_sel_eff;

	assign us_tick = us_cnt_r == 6'(US_CYC - 1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			us_cnt_r <= 6'h00;
		end else if (us_tick) begin
			us_cnt_r <= 6'h00;
		end else begin
			us_cnt_r <= us_cnt_r + 6'h01;
		end
	end

	// codes above the table fall back to the longest ramp
	assign ramp_sel_eff = ramp_sel > RAMP_SEL_MAX ? RAMP_SEL_MAX : ramp_sel;
	assign ramp_step = RAMP_FULL >> (ramp_sel_eff - 4'h1);
	// ramp only matters for on-off keying; frequency shift holds the carrier
	assign ramp_target = pa_en && (ook_mode ? pin_level : 1'b1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ramp_pos_r <= 11'h000;
		end else if (!ook_mode || ramp_sel_eff == 4'h0) begin
			ramp_pos_r <= ramp_target ? RAMP_FULL : 11'h000;
		end else if (us_tick) begin
			// same step both ways keeps ramp-down equal to ramp-up
			if (ramp_target) begin
				ramp_pos_r <= (RAMP_FULL - ramp_pos_r <= ramp_step) ? RAMP_FULL : ramp_pos_r + ramp_step;
			end else begin
				ramp_pos_r <= (ramp_pos_r <= ramp_step) ? 11'h000 : ramp_pos_r - ramp_step;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pa_level_r <= 8'h00;
		end else begin
			pa_level_r <= ramp_pos_r[10] ? PA_LEVEL_MAX : ramp_pos_r[9:2];
		end
	end

endmodule

// file: tsc_core_chk.sv
module tsc_core_chk import tsc_pkg::*; #(
	parameter int XTAL_CYC = XTAL_SETTLE_CYC,
	parameter int TUNE_CYC_P = TUNE_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// configuration
	input wire logic ook_mode,
	input wire logic [3:0] ramp_sel,
	// state and controls
	input wire tsc_state_t state_r,
	input wire logic osc_en,
	input wire logic synth_en,
	input wire logic pa_en,
	input wire logic tx_bit_r,
	input wire logic [7:0] pa_level_r,
	input wire logic port_locked,
	input wire logic calib_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// dwell of the previous state, readable on the first cycle of the next
	tsc_state_t st_r;
	logic [31:0] cnt_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= TSC_SLEEP;
			cnt_r <= '0;
		end else begin
			st_r <= state_r;
			cnt_r <= (state_r == st_r) ? cnt_r + 32'h1 : 32'h1;
		end
	end
	property p_sleep_off; state_r == TSC_SLEEP |-> !osc_en && !synth_en && !pa_en; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("enable on in sleep");
	property p_early; state_r != TSC_TRANSMIT |-> !pa_en && !tx_bit_r; endproperty
	a_early: assert property (p_early) else $error("amplifier or data before transmit");
	property p_warm_len; state_r == TSC_TUNE && st_r == TSC_OSC_WARMUP |-> cnt_r == XTAL_CYC; endproperty
	a_warm_len: assert property (p_warm_len) else $error("warmup length wrong");
	property p_tune_len; state_r == TSC_TRANSMIT |-> st_r == TSC_TRANSMIT || cnt_r == TUNE_CYC_P; endproperty
	a_tune_len: assert property (p_tune_len) else $error("tune length wrong");
	property p_fsk; (state_r == TSC_TRANSMIT && !ook_mode) [*3] |-> pa_level_r == PA_LEVEL_MAX; endproperty
	a_fsk: assert property (p_fsk) else $error("fsk level not full");
	property p_ramp0; (state_r == TSC_TRANSMIT && ook_mode && ramp_sel == 4'h0 && tx_bit_r) [*3] |-> pa_level_r == PA_LEVEL_MAX;
	endproperty
	a_ramp0: assert property (p_ramp0) else $error("zero ramp not immediate");
	property p_calib; calib_busy && $past(calib_busy) |-> state_r == TSC_SLEEP; endproperty
	a_calib: assert property (p_calib) else $error("active during calibration");
	property p_gate; state_r == TSC_OSC_WARMUP && st_r == TSC_SLEEP |-> !port_locked && !calib_busy; endproperty
	a_gate: assert property (p_gate) else $error("start while locked");
	c_tx: cover property (state_r == TSC_TRANSMIT);
	c_calib: cover property (calib_busy);
	c_lock: cover property (port_locked);
endmodule

bind tsc_core tsc_core_chk #(.XTAL_CYC(XTAL_CYC), .TUNE_CYC_P(TUNE_CYC_P)) chk (.clock(clock), .reset_n(reset_n),
	.ook_mode(ook_mode), .ramp_sel(ramp_sel), .state_r(state_r), .osc_en(osc_en), .synth_en(synth_en),
	.pa_en(pa_en), .tx_bit_r(tx_bit_r), .pa_level_r(pa_level_r), .port_locked(port_locked),
	.calib_busy(calib_busy));

// file: tsc_host.sv
module tsc_host import tsc_pkg::*; (
	// pins toward the device
	output logic port_clk,
	output logic host_d,
	output logic host_oe,
	// resolved pin level
	input wire logic pin
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		port_clk = 1'b1; // clock stands high outside frames
		host_d = 1'b0;
		host_oe = 1'b1;
	end
	task automatic setd(input logic v);
		host_d = v; // held until next call
	endtask
	// data changes with clock high, device samples on the fall
	task automatic bit_io(input logic b, output logic s);
		host_d = b;
		#6 port_clk = 1'b0;
		s = pin;
		#6 port_clk = 1'b1;
	endtask
	task automatic send(input logic [15:0] w, output logic [7:0] rd);
		logic s;
		for (int i = 15; i >= 0; i--) begin
			host_oe = !(w[15:14] == 2'b11 && i < 8);
			bit_io(w[i], s);
			if (i < 8) rd[i] = s;
		end
		host_oe = 1'b1;
	endtask
	task automatic resync(output logic [7:0] rd);
		logic s;
		host_d = 1'b0;
		#100;
		for (int i = 0; i < 32; i++) bit_io(1'b0, s);
		send(PORT_RESYNC_PAT, rd);
	endtask
endmodule

// file: tsc_core_test.sv
module tsc_core_test;
	timeunit 1ns;
	timeprecision 100ps;
	import tsc_pkg::*;
	localparam int XC = 40;
	localparam int TC = 30;
	localparam int MC = 50;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic start_falling = 1'b0;
	logic ook_mode = 1'b0;
	logic [3:0] ramp_sel = 4'h0;
	logic [6:0] stop_ms = 7'h02;
	logic pin_last = 1'b0;
	logic [7:0] rd;
	wire port_clk, host_d, host_oe, pin, data_out, data_oe_n, osc_en, synth_en, pa_en, tx_bit_r, port_locked, calib_busy;
	wire [7:0] pa_level_r;
	tsc_state_t state_r;
	int n_fail = 0;
	int n_compared = 0;
	// an undriven pin toggles so a stale level is never mistaken for data
	always @(posedge clock) pin_last <= pin;
	assign pin = !data_oe_n ? data_out : (host_oe ? host_d : ~pin_last);
	tsc_host host (.port_clk(port_clk), .host_d(host_d), .host_oe(host_oe), .pin(pin));
	tsc_core #(.XTAL_CYC(XC), .TUNE_CYC_P(TC), .MS_CYC_P(MC)) uut (.clock(clock), .reset_n(reset_n),
		.port_clk(port_clk), .data_in(pin), .data_out(data_out), .data_oe_n(data_oe_n),
		.start_falling(start_falling), .ook_mode(ook_mode), .ramp_sel(ramp_sel), .stop_ms(stop_ms),
		.state_r(state_r), .osc_en(osc_en), .synth_en(synth_en), .pa_en(pa_en), .tx_bit_r(tx_bit_r),
		.pa_level_r(pa_level_r), .port_locked(port_locked), .calib_busy(calib_busy));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_st(input tsc_state_t s, input int lim);
		for (int i = 0; i < lim && state_r !== s; i++) @(negedge clock);
		check(state_r, s);
		if (state_r !== s) summarize();
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	initial begin
		idle(8);
		reset_n = 1'b1;
		check({state_r, osc_en, synth_en, pa_en, data_oe_n, port_locked}, 7'h02);
		// frequency shift must ignore a nonzero ramp setting
		ramp_sel = 4'h3;
		host.setd(1'b1);
		wait_st(TSC_OSC_WARMUP, 8);
		check({osc_en, synth_en, pa_en}, 3'h4);
		host.setd(1'b0);
		wait_st(TSC_TUNE, XC + 2);
		host.setd(1'b1);
		idle(6);
		check({synth_en, pa_en, tx_bit_r}, 3'h4);
		wait_st(TSC_TRANSMIT, TC + 2);
		idle(3);
		check({pa_en, tx_bit_r, pa_level_r}, 10'h3ff);
		host.setd(1'b0);
		idle(2 * MC - 5);
		check({state_r, tx_bit_r}, {TSC_TRANSMIT, 1'b0});
		wait_st(TSC_SLEEP, 15);
		host.resync(rd);
		host.send(CORE_RESET_PAT, rd);
		idle(8);
		check({port_locked, calib_busy}, 2'h3);
		idle(MC + 5);
		check(calib_busy, 1'b0);
		host.send({2'b10, 6'h2a, 8'ha5}, rd);
		host.send({2'b11, 6'h2a, 8'h00}, rd);
		check(rd, 8'ha5);
		host.setd(1'b1);
		idle(10);
		check(state_r, TSC_SLEEP);
		start_falling = 1'b1;
		host.send(PORT_RELEASE_PAT, rd);
		idle(8);
		check({port_locked, pin}, 2'h1);
		ook_mode = 1'b1;
		ramp_sel = 4'h0;
		host.setd(1'b0);
		wait_st(TSC_OSC_WARMUP, 8);
		wait_st(TSC_TRANSMIT, XC + TC + 4);
		host.setd(1'b1);
		idle(6);
		check(pa_level_r, PA_LEVEL_MAX);
		// 4 us ramp; an illegal stop time falls back to 20 ms, so 600 clocks low keep transmit
		ramp_sel = 4'h3;
		stop_ms = 7'h0b;
		host.setd(1'b0);
		idle(60);
		check(pa_level_r != 8'hff && pa_level_r != 8'h00, 1'b1);
		idle(540);
		check({state_r, pa_level_r}, {TSC_TRANSMIT, 8'h00});
		host.setd(1'b1);
		idle(260);
		check(pa_level_r, PA_LEVEL_MAX);
		host.resync(rd);
		host.send(CORE_RESET_PAT, rd);
		idle(8);
		check({state_r, pa_en, calib_busy}, {TSC_SLEEP, 2'h1});
		idle(MC + 5);
		host.setd(1'b1);
		idle(4);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		summarize();
	end
endmodule
